// *** common/lbs_defines.vh ***
// constants for the locator burst scheduler: register map, field layout,
// default position values and slot timing figures.
// assumes inclusion by bare name from the design files.
`ifndef LBS_DEFINES_VH
`define LBS_DEFINES_VH

// register map, byte addresses on the wishbone bus
`define LBS_ADR_CTRL 8'h00
`define LBS_ADR_STATUS 8'h04
`define LBS_ADR_GAP 8'h08

// control register bits
`define LBS_CTRL_ACTIVE_GO 0
`define LBS_CTRL_TEST_GO 1
`define LBS_CTRL_STOP 2
`define LBS_CTRL_START_CH2 3

// slots between burst starts, one minute of slot time
`define LBS_GAP_RESET 12'h8CA
// random increment window, inclusive (2025 .. 2475); span is the largest offset
`define LBS_INCR_MIN 12'h7E9
`define LBS_INCR_SPAN 9'h1C2

// message field values
`define LBS_NAV_ACTIVE 4'hE
`define LBS_NAV_TEST 4'hF
`define LBS_TS_NONE 6'h3F
`define LBS_SYNC_DIRECT 2'h0
`define LBS_SYNC_NONE 2'h3
`define LBS_LON_NONE 28'h6791AC0
`define LBS_LAT_NONE 27'h3412140
`define LBS_COG_NONE 12'hE10
`define LBS_SOG_NONE 10'h3FF
`define LBS_TMO_FIRST 3'h7

// burst shape
`define LBS_MSGS_PER_BURST 8
`define LBS_BURSTS_PER_CYCLE 8

// queued word layout, lsb of each field
`define LBS_W_TS 0
`define LBS_W_SOG 6
`define LBS_W_COG 16
`define LBS_W_LAT 28
`define LBS_W_LON 55
`define LBS_W_SUB 83
`define LBS_W_TMO 97
`define LBS_W_SYNC 100
`define LBS_W_NAV 102
`define LBS_W_TXT 106
`define LBS_W_SAFETY 107
`define LBS_W_CH 108
`define LBS_W_WIDTH 109

`endif

// *** src/lbs_fifo.v ***
// small first-in first-out queue with a registered output stage.
// assumes one clock; source and sink use valid/ready handshakes.
`timescale 1ns/1ps
module lbs_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire mclk,
    input wire nrst,
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0] wr_ptr_reg;
reg [AW-1:0] rd_ptr_reg;
reg [AW:0] count_reg;
wire push;
wire pop;

////////////////////////////////////////////////////////////////////////
// output stage refills whenever it is empty or being taken
assign in_ready = (count_reg < DEPTH);
assign push = in_valid && in_ready;
assign pop = (count_reg != 0) && (!out_valid || out_ready);

always @(posedge mclk) begin
    if (push) begin
        mem[wr_ptr_reg] <= in_data;
    end
end

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        wr_ptr_reg <= {AW{1'b0}};
        rd_ptr_reg <= {AW{1'b0}};
        count_reg <= {(AW+1){1'b0}};
        out_valid <= 1'b0;
        out_data <= {WIDTH{1'b0}};
    end else begin
        if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
        end
        if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == DEPTH - 1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
            out_data <= mem[rd_ptr_reg];
            out_valid <= 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
        if (push && !pop) begin
            count_reg <= count_reg + 1'b1;
        end else if (pop && !push) begin
            count_reg <= count_reg - 1'b1;
        end
    end
end

endmodule

// *** src/lbs_rand.v ***
// pseudo random slot increment source, free running lfsr.
// assumes one clock; the value is always inside the allowed window.
`timescale 1ns/1ps
`include "lbs_defines.vh"
module lbs_rand (
    input wire mclk,
    input wire nrst,
    output reg [11:0] incr
);

reg [15:0] lfsr_reg;
wire [8:0] raw;
wire [8:0] fold;

////////////////////////////////////////////////////////////////////////
// fold keeps the window inclusive; slight bias on low values is accepted
assign raw = lfsr_reg[8:0];
assign fold = (raw > `LBS_INCR_SPAN) ? raw - `LBS_INCR_SPAN - 9'h001 : raw;

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        lfsr_reg <= 16'hACE1;
        incr <= `LBS_INCR_MIN;
    end else begin
        lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
        incr <= `LBS_INCR_MIN + {3'h0, fold};
    end
end

endmodule

// *** src/lbs_scheduler.v ***
// locator burst scheduler: builds the beacon message bursts and queues
// them for the radio modem.
// assumes slot timing and position inputs come from logic on mclk.
//
// Functional notes
// RQ1 - active mode sends one eight-message burst per minute, pre-announcing transmissions
// RQ2 - consecutive messages of a burst alternate between the two channels
// RQ3 - bursts one and five: status 14, time-out 7 or 3, safety at slots 5,6
// RQ4 - bursts two, four, six: status 14, time-out 6,4,2, sub-message slot
// RQ5 - burst three: eight reports, status 14, time-out 5, sub-message 0
// RQ6 - burst seven: status 14, time-out 1, sub-message carries utc time
// RQ7 - burst eight: status 14, time-out 0, sub-message carries slot increment
// RQ8 - increment after burst eight random, inclusive 2025 to 2475 slots
// RQ9 - after burst eight the cycle restarts at burst one while active
// RQ10 - alternation may start on the second channel, active and test
// RQ11 - safety broadcast only in bursts one and five
// RQ12 - test mode sends exactly one burst, eight messages, four per channel
// RQ13 - test burst: safety first and last, six reports status 15, zeros
// RQ14 - no fix: longitude 181, latitude 91, course/speed unavailable, stamp 63
// RQ15 - fix lost in active mode: keep last position, course and speed
// RQ16 - while on last known position: time stamp 63, sync state 3
// RQ17 - burst and slot indices select every field of each message; position fields follow the fix state instead; code: status and text flag follow the mode
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "lbs_defines.vh"
module lbs_scheduler #(
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2
) (
    input wire mclk,
    input wire nrst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire slot_tick,
    input wire [11:0] slot_num,
    input wire [13:0] utc_time,
    input wire pos_valid,
    input wire [27:0] pos_lon,
    input wire [26:0] pos_lat,
    input wire [11:0] pos_cog,
    input wire [9:0] pos_sog,
    input wire [5:0] pos_ts,
    output wire tx_valid,
    input wire tx_ready,
    output wire tx_channel,
    output wire tx_safety,
    output wire tx_text_test,
    output wire [3:0] tx_nav,
    output wire [1:0] tx_sync,
    output wire [2:0] tx_timeout,
    output wire [13:0] tx_submsg,
    output wire [27:0] tx_lon,
    output wire [26:0] tx_lat,
    output wire [11:0] tx_cog,
    output wire [9:0] tx_sog,
    output wire [5:0] tx_ts
);

localparam ST_IDLE = 2'b00;
localparam ST_WAIT = 2'b01;
localparam ST_EMIT = 2'b10;

reg [1:0] state_reg;
reg active_reg;
reg test_reg;
reg start_ch2_reg;
reg [11:0] gap_reg;
reg [11:0] gap_cnt_reg;
reg [2:0] burst_reg;
reg [2:0] slot_reg;
reg ch_reg;
reg [11:0] incr_reg;
reg have_fix_reg;
reg [27:0] last_lon_reg;
reg [26:0] last_lat_reg;
reg [11:0] last_cog_reg;
reg [9:0] last_sog_reg;
wire [11:0] rand_incr;
wire fifo_in_ready;
wire [`LBS_W_WIDTH-1:0] fifo_out;
wire push;
wire bus_req;
wire bus_wr;
wire go_active;
wire go_test;
wire go_stop;

////////////////////////////////////////////////////////////////////////
// wishbone slave: ack one cycle after the request, dropped after one

assign bus_req = wb_cyc_i && wb_stb_i;
// write takes effect at the edge where the master sees ack
assign bus_wr = bus_req && wb_we_i && wb_ack_o;
assign go_active = bus_wr && (wb_adr_i == `LBS_ADR_CTRL) && wb_sel_i[0] &&
    wb_dat_i[`LBS_CTRL_ACTIVE_GO];
assign go_test = bus_wr && (wb_adr_i == `LBS_ADR_CTRL) && wb_sel_i[0] &&
    wb_dat_i[`LBS_CTRL_TEST_GO];
assign go_stop = bus_wr && (wb_adr_i == `LBS_ADR_CTRL) && wb_sel_i[0] &&
    wb_dat_i[`LBS_CTRL_STOP];

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h00000000;
        start_ch2_reg <= 1'b0;
        gap_reg <= `LBS_GAP_RESET;
    end else begin
        wb_ack_o <= bus_req && !wb_ack_o;
        if (bus_req && !wb_ack_o && !wb_we_i) begin
            if (wb_adr_i == `LBS_ADR_CTRL) begin
                wb_dat_o <= {28'h0000000, start_ch2_reg, 3'h0};
            end else if (wb_adr_i == `LBS_ADR_STATUS) begin
                wb_dat_o <= {4'h0, incr_reg, 2'h0, have_fix_reg && !pos_valid,
                    have_fix_reg, 1'b0, slot_reg, 1'b0, burst_reg, 2'h0, test_reg,
                    active_reg};
            end else if (wb_adr_i == `LBS_ADR_GAP) begin
                wb_dat_o <= {20'h00000, gap_reg};
            end else begin
                wb_dat_o <= 32'h00000000;
            end
        end
        if (bus_wr && (wb_adr_i == `LBS_ADR_CTRL) && wb_sel_i[0]) begin
            start_ch2_reg <= wb_dat_i[`LBS_CTRL_START_CH2]; // RQ10
        end
        if (bus_wr && (wb_adr_i == `LBS_ADR_GAP)) begin
            if (wb_sel_i[0]) begin
                gap_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                gap_reg[11:8] <= wb_dat_i[11:8];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////
// position memory: last good fix is kept for when the receiver drops out

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        have_fix_reg <= 1'b0;
        last_lon_reg <= `LBS_LON_NONE;
        last_lat_reg <= `LBS_LAT_NONE;
        last_cog_reg <= `LBS_COG_NONE;
        last_sog_reg <= `LBS_SOG_NONE;
    end else begin
        if (go_active || go_test) begin
            // a fresh activation forgets any old fix
            have_fix_reg <= pos_valid;
        end else if (pos_valid) begin
            have_fix_reg <= 1'b1;
        end
        if (pos_valid) begin
            last_lon_reg <= pos_lon; // RQ15
            last_lat_reg <= pos_lat;
            last_cog_reg <= pos_cog;
            last_sog_reg <= pos_sog;
        end
    end
end

////////////////////////////////////////////////////////////////////////
// message fields chosen from mode, burst and slot index; position fields from the fix state

reg is_safety;
reg [3:0] f_nav;
reg [2:0] f_tmo;
reg [13:0] f_sub;
reg [1:0] f_sync;
reg [27:0] f_lon;
reg [26:0] f_lat;
reg [11:0] f_cog;
reg [9:0] f_sog;
reg [5:0] f_ts;

always @* begin
    if (test_reg) begin
        is_safety = (slot_reg == 3'h0) || (slot_reg == 3'h7); // RQ13
        f_nav = `LBS_NAV_TEST; // RQ13
        f_tmo = 3'h0;
        f_sub = 14'h0000;
    end else begin
        is_safety = ((burst_reg == 3'h0) || (burst_reg == 3'h4)) &&
            ((slot_reg == 3'h4) || (slot_reg == 3'h5)); // RQ3 RQ11
        f_nav = `LBS_NAV_ACTIVE;
        f_tmo = `LBS_TMO_FIRST - burst_reg; // RQ3 RQ4 RQ5 RQ6 RQ7
        if (burst_reg == 3'h1 || burst_reg == 3'h3 || burst_reg == 3'h5) begin
            f_sub = {2'h0, slot_num}; // RQ4
        end else if (burst_reg == 3'h6) begin
            f_sub = utc_time; // RQ6
        end else if (burst_reg == 3'h7) begin
            f_sub = {2'h0, incr_reg}; // RQ7
        end else begin
            f_sub = 14'h0000; // RQ3 RQ5
        end
    end
    if (pos_valid) begin
        f_lon = pos_lon;
        f_lat = pos_lat;
        f_cog = pos_cog;
        f_sog = pos_sog;
        f_ts = pos_ts;
        f_sync = `LBS_SYNC_DIRECT;
    end else if (have_fix_reg && active_reg) begin
        f_lon = last_lon_reg; // RQ15
        f_lat = last_lat_reg;
        f_cog = last_cog_reg;
        f_sog = last_sog_reg;
        f_ts = `LBS_TS_NONE; // RQ16
        f_sync = `LBS_SYNC_NONE; // RQ16
    end else begin
        f_lon = `LBS_LON_NONE; // RQ14
        f_lat = `LBS_LAT_NONE;
        f_cog = `LBS_COG_NONE;
        f_sog = `LBS_SOG_NONE;
        f_ts = `LBS_TS_NONE;
        f_sync = `LBS_SYNC_NONE;
    end
end

////////////////////////////////////////////////////////////////////////
// burst sequencer; emission stalls on a full queue, never drops a message

assign push = (state_reg == ST_EMIT) && fifo_in_ready;

always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        state_reg <= ST_IDLE;
        active_reg <= 1'b0;
        test_reg <= 1'b0;
        burst_reg <= 3'h0;
        slot_reg <= 3'h0;
        ch_reg <= 1'b0;
        gap_cnt_reg <= 12'h000;
        incr_reg <= `LBS_INCR_MIN;
    end else if (go_stop) begin
        state_reg <= ST_IDLE;
        active_reg <= 1'b0;
        test_reg <= 1'b0;
    end else if (go_active || go_test) begin
        state_reg <= ST_EMIT;
        active_reg <= go_active;
        test_reg <= go_test && !go_active;
        burst_reg <= 3'h0; // RQ17
        slot_reg <= 3'h0;
        // the go write's own lane bit applies, not the one it replaces
        ch_reg <= wb_dat_i[`LBS_CTRL_START_CH2]; // RQ10
        gap_cnt_reg <= gap_reg;
    end else begin
        case (state_reg)
            ST_IDLE: begin
                slot_reg <= 3'h0;
            end
            ST_WAIT: begin
                if (slot_tick) begin
                    if (gap_cnt_reg <= 12'h001) begin
                        state_reg <= ST_EMIT; // RQ1
                        ch_reg <= start_ch2_reg; // RQ10
                        gap_cnt_reg <= gap_reg;
                        if (burst_reg == 3'h7) begin
                            incr_reg <= rand_incr; // RQ8
                        end
                    end else begin
                        gap_cnt_reg <= gap_cnt_reg - 12'h001;
                    end
                end
            end
            ST_EMIT: begin
                if (slot_tick && gap_cnt_reg > 12'h001) begin
                    gap_cnt_reg <= gap_cnt_reg - 12'h001;
                end
                if (push) begin
                    ch_reg <= !ch_reg; // RQ2
                    slot_reg <= slot_reg + 3'h1; // RQ17
                    if (slot_reg == 3'h7) begin
                        if (test_reg) begin
                            state_reg <= ST_IDLE; // RQ12
                            test_reg <= 1'b0;
                        end else begin
                            state_reg <= ST_WAIT;
                            burst_reg <= burst_reg + 3'h1; // RQ9
                            if (burst_reg == 3'h7) begin
                                gap_cnt_reg <= incr_reg; // RQ8
                            end
                        end
                    end
                end
            end
            default: begin
                state_reg <= ST_IDLE;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////
// random increment source and modem queue

lbs_rand u_rand (
    .mclk(mclk),
    .nrst(nrst),
    .incr(rand_incr)
);

lbs_fifo #(
    .WIDTH(`LBS_W_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
) u_fifo (
    .mclk(mclk),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data({ch_reg, is_safety, test_reg, f_nav, f_sync, f_tmo, f_sub,
        f_lon, f_lat, f_cog, f_sog, f_ts}),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(fifo_out)
);

assign tx_channel = fifo_out[`LBS_W_CH];
assign tx_safety = fifo_out[`LBS_W_SAFETY];
assign tx_text_test = fifo_out[`LBS_W_TXT];
assign tx_nav = fifo_out[`LBS_W_NAV+3:`LBS_W_NAV];
assign tx_sync = fifo_out[`LBS_W_SYNC+1:`LBS_W_SYNC];
assign tx_timeout = fifo_out[`LBS_W_TMO+2:`LBS_W_TMO];
assign tx_submsg = fifo_out[`LBS_W_SUB+13:`LBS_W_SUB];
assign tx_lon = fifo_out[`LBS_W_LON+27:`LBS_W_LON];
assign tx_lat = fifo_out[`LBS_W_LAT+26:`LBS_W_LAT];
assign tx_cog = fifo_out[`LBS_W_COG+11:`LBS_W_COG];
assign tx_sog = fifo_out[`LBS_W_SOG+9:`LBS_W_SOG];
assign tx_ts = fifo_out[`LBS_W_TS+5:`LBS_W_TS];

endmodule

// *** test/lbs_sched_sva.sv ***
// checker for the burst scheduler: bus answer and message stream rules.
// assumes it is bound to lbs_scheduler and sees only its ports.
`timescale 1ns/1ps
`include "lbs_defines.vh"
module lbs_sched_sva (
    input wire mclk,
    input wire nrst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire tx_valid,
    input wire tx_ready,
    input wire tx_channel,
    input wire tx_safety,
    input wire tx_text_test,
    input wire [3:0] tx_nav,
    input wire [1:0] tx_sync,
    input wire [2:0] tx_timeout,
    input wire [13:0] tx_submsg,
    input wire [27:0] tx_lon,
    input wire [26:0] tx_lat,
    input wire [11:0] tx_cog,
    input wire [5:0] tx_ts
);
////////////////////////////////////////////////////////////////
// word position inside the burst; a stop or go write can cut a burst short, so a wrap marks a new one only for whole bursts
reg [2:0] idx_reg;
reg prev_ch_reg;
wire take = tx_valid && tx_ready;
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        idx_reg <= 3'h0;
        prev_ch_reg <= 1'b0;
    end else if (take) begin
        idx_reg <= idx_reg + 3'h1;
        prev_ch_reg <= tx_channel;
    end
end
default clocking cb @(posedge mclk); endclocking
default disable iff (!nrst);
////////////////////////////////////////////////////////////////
chk_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
chk_ack_drop: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
chk_word_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_submsg))
    else $error("stalled word changed");
chk_ch_alternate: assert property (take && idx_reg != 3'h0 |-> tx_channel != prev_ch_reg)
    else $error("channel did not alternate");
chk_safety_place: assert property (take && tx_safety && !tx_text_test |-> idx_reg[2:1] == 2'h2)
    else $error("active safety word off slots 5 and 6");
chk_test_ends: assert property (take && tx_safety && tx_text_test |-> idx_reg == 3'h0 || idx_reg == 3'h7)
    else $error("test safety word not first or last");
chk_nav_active: assert property (tx_valid && !tx_safety && !tx_text_test |-> tx_nav == 4'hE)
    else $error("active report status wrong");
chk_test_fields: assert property (tx_valid && !tx_safety && tx_text_test |-> tx_nav == 4'hF && tx_timeout == 3'h0 && tx_submsg == 14'h0)
    else $error("test report fields wrong");
chk_incr_window: assert property (tx_valid && !tx_safety && !tx_text_test && tx_timeout == 3'h0 |-> tx_submsg >= 14'h7E9 && tx_submsg <= 14'h9AB)
    else $error("increment outside window");
chk_lost_stamp: assert property (tx_valid && !tx_safety && tx_sync == 2'h3 |-> tx_ts == 6'h3F)
    else $error("stamp not 63 without fix");
chk_default_set: assert property (tx_valid && !tx_safety && tx_lon == `LBS_LON_NONE |-> tx_lat == `LBS_LAT_NONE && tx_cog == `LBS_COG_NONE)
    else $error("default position incomplete");
cover property (take && tx_safety && tx_text_test);
cover property (take && tx_safety && !tx_text_test);
cover property (take && !tx_text_test && tx_timeout == 3'h0);
endmodule
bind lbs_scheduler lbs_sched_sva chk_u (.mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .tx_channel(tx_channel), .tx_safety(tx_safety), .tx_text_test(tx_text_test),
    .tx_nav(tx_nav), .tx_sync(tx_sync), .tx_timeout(tx_timeout), .tx_submsg(tx_submsg),
    .tx_lon(tx_lon), .tx_lat(tx_lat), .tx_cog(tx_cog), .tx_ts(tx_ts));

// *** test/lbs_far_end.sv ***
// far side model: modem slot timing, radio sink and position receiver.
// assumes the bench drives stall and fix_on just after a clock edge.
`timescale 1ns/1ps
module lbs_far_end (
    input wire mclk,
    input wire nrst,
    input wire stall,
    input wire fix_on,
    output reg slot_tick,
    output reg [11:0] slot_num,
    output wire [13:0] utc_time,
    output reg tx_ready,
    output wire pos_valid,
    output wire [27:0] pos_lon,
    output wire [26:0] pos_lat,
    output wire [11:0] pos_cog,
    output wire [9:0] pos_sog,
    output wire [5:0] pos_ts
);
////////////////////////////////////////////////////////////////
reg [1:0] ph_reg;
assign utc_time = 14'h1A5;
assign pos_valid = fix_on;
// without a fix the receiver shows junk, so stale data can never pass for held data
assign pos_lon = fix_on ? 28'h0123456 : ~28'h0123456;
assign pos_lat = fix_on ? 27'h0654321 : ~27'h0654321;
assign pos_cog = fix_on ? 12'h0AB : ~12'h0AB;
assign pos_sog = fix_on ? 10'h05C : ~10'h05C;
assign pos_ts = fix_on ? 6'h15 : ~6'h15;
// slot every second cycle keeps the long increment wait short; radio stalls one cycle in four
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        ph_reg <= 2'h0;
        slot_tick <= 1'b0;
        slot_num <= 12'h0;
        tx_ready <= 1'b0;
    end else begin
        ph_reg <= ph_reg + 2'h1;
        slot_tick <= ph_reg[0];
        slot_num <= slot_num + {11'h0, slot_tick};
        tx_ready <= !(stall && ph_reg == 2'h1);
    end
end
endmodule

// *** test/tb_top.sv ***
// bench for the burst scheduler: registers, test burst and a full active cycle.
// assumes the far side model feeds slot timing, radio ready and position data.
`timescale 1ns/1ps
`include "lbs_defines.vh"
module tb_top;
reg mclk = 1'b0;
reg nrst = 1'b0;
reg cyc = 1'b0;
reg stb = 1'b0;
reg we = 1'b0;
reg [7:0] adr = 8'h00;
reg [31:0] dat = 32'h0;
reg fix_on = 1'b0;
integer num_errors = 0;
integer total_checks = 0;
integer cycles = 0;
wire [31:0] rd;
wire ack, tick, pv, tx_valid, tx_ready;
wire [11:0] slot_num, pcog;
wire [13:0] utc;
wire [27:0] plon;
wire [26:0] plat;
wire [9:0] psog;
wire [5:0] pts;
wire [108:0] wd;
logic [108:0] q[$];
reg [31:0] r;
lbs_far_end far_u (.mclk(mclk), .nrst(nrst), .stall(1'b1), .fix_on(fix_on),
    .slot_tick(tick), .slot_num(slot_num), .utc_time(utc), .tx_ready(tx_ready),
    .pos_valid(pv), .pos_lon(plon), .pos_lat(plat), .pos_cog(pcog), .pos_sog(psog),
    .pos_ts(pts));
lbs_scheduler dut_u (.mclk(mclk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rd),
    .wb_ack_o(ack), .slot_tick(tick), .slot_num(slot_num), .utc_time(utc),
    .pos_valid(pv), .pos_lon(plon), .pos_lat(plat), .pos_cog(pcog), .pos_sog(psog),
    .pos_ts(pts), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_channel(wd[108]),
    .tx_safety(wd[107]), .tx_text_test(wd[106]), .tx_nav(wd[105:102]),
    .tx_sync(wd[101:100]), .tx_timeout(wd[99:97]), .tx_submsg(wd[96:83]),
    .tx_lon(wd[82:55]), .tx_lat(wd[54:28]), .tx_cog(wd[27:16]), .tx_sog(wd[15:6]),
    .tx_ts(wd[5:0]));
////////////////////////////////////////////////////////////////
initial forever #2 mclk = ~mclk;
always @(posedge mclk) begin
    if (nrst && tx_valid && tx_ready) q.push_back(wd);
    cycles = cycles + 1;
    if (cycles == 20000) begin
        num_errors = num_errors + 1;
        close_out;
    end
end
task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
        total_checks = total_checks + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("[ERR] %s expected %0h seen %0h", nm, e, g);
        end
    end
endtask
task wb(input [7:0] a, input w, input [31:0] d);
    integer n;
    begin
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        @(posedge mclk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n = n + 1;
        end
        if (ack !== 1'b1) cmp("bus ack", 1, 0);
        r = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge mclk);
    end
endtask
// the wait covers the longest increment gap after the eighth burst
task pop(output logic [108:0] w);
    integer n;
    begin
        n = 0;
        while (q.size() == 0 && n < 6000) begin
            @(posedge mclk);
            n = n + 1;
        end
        w = 'x;
        if (q.size() != 0) w = q.pop_front();
        else cmp("word arrival", 1, 0);
    end
endtask
task close_out;
    begin
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end
endtask
////////////////////////////////////////////////////////////////
task t_regs;
    begin
        wb(`LBS_ADR_GAP, 1'b0, 32'h0);
        cmp("gap reset", 32'h8CA, r);
        wb(`LBS_ADR_STATUS, 1'b0, 32'h0);
        cmp("status reset", 32'h07E90000, r);
        wb(8'h0C, 1'b0, 32'h0);
        cmp("unmapped", 32'h0, r);
        wb(`LBS_ADR_GAP, 1'b1, 32'hC);
        wb(`LBS_ADR_GAP, 1'b0, 32'h0);
        cmp("gap", 32'hC, r);
    end
endtask
task t_test;
    logic [108:0] w;
    integer s;
    logic sf;
    begin
        wb(`LBS_ADR_CTRL, 1'b1, 32'hA);
        for (s = 0; s < 8; s = s + 1) begin
            pop(w);
            sf = (s == 0 || s == 7);
            cmp("channel", s % 2 == 0, w[108]);
            cmp("safety", sf, w[107]);
            cmp("text", 1, w[106]);
            if (!sf) begin
                cmp("nav", 4'hF, w[105:102]);
                cmp("sub", 0, {w[99:97], w[96:83]});
                cmp("lon", `LBS_LON_NONE, w[82:55]);
                cmp("lat", `LBS_LAT_NONE, w[54:28]);
                cmp("cogsog", {`LBS_COG_NONE, `LBS_SOG_NONE}, w[27:6]);
                cmp("stamp", 6'h3F, w[5:0]);
            end
        end
        repeat (200) @(posedge mclk);
        cmp("extra words", 0, q.size());
    end
endtask
task t_active;
    logic [108:0] w;
    logic [13:0] inc;
    integer b, s, bi;
    logic sf;
    begin
        fix_on <= 1'b1;
        wb(`LBS_ADR_CTRL, 1'b1, 32'h1);
        for (b = 0; b < 9; b = b + 1) begin
            bi = b % 8;
            for (s = 0; s < 8; s = s + 1) begin
                pop(w);
                sf = (bi == 0 || bi == 4) && (s == 4 || s == 5);
                cmp("channel", s % 2, w[108]);
                cmp("safety", sf, w[107]);
                cmp("text", 0, w[106]);
                if (!sf) begin
                    cmp("nav", 4'hE, w[105:102]);
                    cmp("timeout", 7 - bi, w[99:97]);
                    if (bi == 7 && s == 0) inc = w[96:83];
                    if (bi == 6) cmp("utc", 14'h1A5, w[96:83]);
                    else if (bi == 7) cmp("incr", inc, w[96:83]);
                    else if (bi % 2) cmp("slot", 1, slot_num - w[94:83] < 12'h10);
                    else cmp("sub", 0, w[96:83]);
                    cmp("lon", 28'h0123456, w[82:55]);
                    cmp("cog", 12'h0AB, w[27:16]);
                    cmp("lat", 27'h0654321, w[54:28]);
                    cmp("sog", 10'h05C, w[15:6]);
                    cmp("stamp", b < 2 ? 6'h15 : 6'h3F, w[5:0]);
                    cmp("sync", b < 2 ? 2'h0 : 2'h3, w[101:100]);
                end
            end
            // all words of burst three are queued after this point, so they see the lost fix
            if (b == 1) fix_on <= 1'b0;
            if (b == 7) begin
                cmp("incr window", 1, inc >= 14'h7E9 && inc <= 14'h9AB);
                wb(`LBS_ADR_STATUS, 1'b0, 32'h0);
                cmp("status incr", inc, r[27:16]);
            end
        end
        wb(`LBS_ADR_CTRL, 1'b1, 32'h4);
    end
endtask
initial begin
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    t_regs;
    t_test;
    t_active;
    close_out;
end
endmodule
